// File: design/flvds_tx.sv
// Flat panel differential transmitter: pixel capture, pairing, rate generation, power.
//
// Functional notes
// - Colour depth of 6 or 8 bits, and single or dual channel, are configurable.
// - One pixel is taken on every rising edge of the dot clock.
// - Serial bit rate is a fixed multiple of dot clock, set by channel mode.
// - Single channel sends 18 or 24 colour bits plus three timing bits on three or four pairs.
// - Dual channel sends 36 or 48 colour bits plus timing on six or eight pairs.
// - The dot clock must lie between 25 MHz and 112 MHz.
// - Locked panel timing ignores further writes until the lock is released.
// - After locking, modes change only through source size or legacy graphics.
// - Sync and enable timing keep flowing unbroken through any mode change.
// - Each pair can be powered down individually and then sits in low power.
// - A cleared port enable puts every pair in low power.
// - The power sequencer may override driver power states while sequencing.
// - Dual channel splits even and odd pixels; first active pixel goes to A.
// - Dual channel horizontal timings must lie on even pixel counts.
// - Each clock pair sends 1100011 once per load period, slot aligned.
// - Shift rate is 7x pixel rate single, 3.5x dual; load 1x or 0.5x.
`timescale 1ns/1ns
module flvds_tx
(
	// System clock and reset
	input  wire logic        CLOCK,
	input  wire logic        SYS_RST,
	// Pixel stream from the display pipe, on the dot clock
	input  wire logic        DOT_CLK,
	input  wire logic [23:0] PIX_DATA,
	input  wire logic        PIX_HSYNC,
	input  wire logic        PIX_VSYNC,
	input  wire logic        PIX_DISPLAY_ACTIVE_FLAG,
	// Port configuration
	input  wire logic        PORT_ENABLE,
	input  wire logic        CFG_DUAL_CHANNEL,
	input  wire logic        CFG_COLOR_8BIT,
	input  wire logic [9:0]  PAIR_PD_SEL,
	// Power sequencer override
	input  wire logic        SEQ_OVERRIDE_EN,
	input  wire logic        SEQ_IN_PROGRESS,
	input  wire logic        SEQ_DRIVERS_ON,
	// Panel timing and mode control
	input  wire logic        TMG_WR,
	input  wire logic [31:0] TMG_WR_DATA,
	input  wire logic        TMG_LOCK_SET,
	input  wire logic        TMG_LOCK_CLR,
	input  wire logic        SRC_SIZE_WR,
	input  wire logic [23:0] SRC_SIZE_DATA,
	input  wire logic        LEGACY_GFX_EN,
	// Serial pairs and their power state
	output wire logic [9:0]  LVDS_SERIAL,
	output wire logic [9:0]  PAIR_POWER_ON,
	// Status
	output wire logic [31:0] TMG_VALUE,
	output wire logic        TMG_LOCKED,
	output wire logic [23:0] ACTIVE_SRC_SIZE,
	output wire logic        HIGH_RESOLUTION_MODE,
	output wire logic        TMG_PARITY_ERR,
	output wire logic        LINK_RATE_OK
);

	////////////////////////////////////////////////////////////////////////////////
	// Synchronisers and shifter

	localparam int PW = flvds_pkg::PIX_W + 3;

	logic          dot_s2;
	logic          dot_s3;
	logic [PW-1:0] pix_s2;
	logic [PW-1:0] pix_s3;

	flvds_sync3 #(.W(1)) u_dot_sync
	(
		.clk    (CLOCK),
		.rst    (SYS_RST),
		.din    (DOT_CLK),
		.stage2 (dot_s2),
		.stage3 (dot_s3)
	);

	flvds_sync3 #(.W(PW)) u_pix_sync
	(
		.clk    (CLOCK),
		.rst    (SYS_RST),
		.din    ({PIX_DISPLAY_ACTIVE_FLAG, PIX_VSYNC, PIX_HSYNC, PIX_DATA}),
		.stage2 (pix_s2),
		.stage3 (pix_s3)
	);

	flvds_ser_if ser ();

	flvds_shifter u_shifter
	(
		.clk (CLOCK),
		.rst (SYS_RST),
		.ser (ser.shifter)
	);

	////////////////////////////////////////////////////////////////////////////////
	// State

	flvds_pkg::flvds_top_t r;
	flvds_pkg::flvds_top_t n;

	logic                                                  dot_rise;
	logic [PW-1:0]                                         pix;
	flvds_pkg::flvds_chan_t                                packed_pix;
	logic [9:0]                                            sum;
	logic [9:0]                                            modulus;
	logic [9:0]                                            need;
	logic [flvds_pkg::NUM_PAIRS-1:0][flvds_pkg::WORD_W-1:0] words;

	always_comb
	begin
		n          = r;
		dot_rise   = 1'b0;
		pix        = r.pix_prev;
		packed_pix = '0;
		sum        = '0;
		modulus    = '0;
		need       = '0;
		words      = '0;
		n.shift    = 1'b0;
		n.load     = 1'b0;

		// Port enable follows its input one cycle later; reset leaves it clear.
		n.port_en = PORT_ENABLE;

		// Lock: setting wins when both arrive together.
		if (TMG_LOCK_SET)
			n.lock = 1'b1;
		else if (TMG_LOCK_CLR)
			n.lock = 1'b0;
		if (TMG_WR && !r.lock)
			n.tmg = TMG_WR_DATA;

		// Source size and legacy graphics stay writable; they never touch the stream.
		if (SRC_SIZE_WR)
			n.src_size = SRC_SIZE_DATA;
		n.legacy = LEGACY_GFX_EN;

		n.tmg_err = CFG_DUAL_CHANNEL & (r.tmg[flvds_pkg::TMG_HACT_LSB]
			| r.tmg[flvds_pkg::TMG_HSYNC_LSB] | r.tmg[flvds_pkg::TMG_HBLANK_LSB]);

		//////////////////////////////////////////////////////////////////////////
		// Dot clock edge: a change counts once stages two and three agree.
		if (dot_s2 == dot_s3)
			n.dot_lvl = dot_s3;
		dot_rise   = n.dot_lvl & ~r.dot_lvl;
		n.pix_prev = pix_s3;

		// Period measure between edges; a stopped dot clock saturates the count.
		if (dot_rise)
		begin
			n.per_cnt = '0;
			n.period  = (r.per_cnt == '1) ? r.per_cnt : r.per_cnt + 8'h01;
		end
		else if (r.per_cnt != '1)
		begin
			n.per_cnt = r.per_cnt + 8'h01;
		end
		n.rate_ok = (r.period >= flvds_pkg::PERIOD_MIN_CYC)
			&& (r.period <= flvds_pkg::PERIOD_MAX_CYC);

		//////////////////////////////////////////////////////////////////////////
		// Pixel capture: the word seen just before the edge is the pixel.
		packed_pix = flvds_pkg::flvds_pack(pix[flvds_pkg::PIX_W-1:0],
			pix[flvds_pkg::PIX_W], pix[flvds_pkg::PIX_W+1], pix[flvds_pkg::PIX_W+2],
			CFG_COLOR_8BIT);
		if (dot_rise)
		begin
			n.de_prev = pix[flvds_pkg::PIX_W+2];
			if (!CFG_DUAL_CHANNEL)
			begin
				n.ready_a = packed_pix;
				n.ready_b = '0;
				n.pair    = flvds_pkg::PAIR_A;
			end
			else if (pix[flvds_pkg::PIX_W+2] && !r.de_prev)
			begin
				// A half-filled pair at the start of active video is dropped.
				n.hold = packed_pix;
				n.pair = flvds_pkg::PAIR_B;
			end
			else
			begin
				case (r.pair)
					flvds_pkg::PAIR_A:
					begin
						n.hold = packed_pix;
						n.pair = flvds_pkg::PAIR_B;
					end
					flvds_pkg::PAIR_B:
					begin
						n.ready_a = r.hold;
						n.ready_b = packed_pix;
						n.pair    = flvds_pkg::PAIR_A;
					end
					default:
					begin
						n.pair = flvds_pkg::PAIR_A;
					end
				endcase
			end
		end

		//////////////////////////////////////////////////////////////////////////
		// Shift enables: seven per load period, spread evenly by an accumulator.
		// The load period is one dot period single, two dot periods dual.
		modulus = CFG_DUAL_CHANNEL ? {1'b0, r.period, 1'b0} : {2'b00, r.period};
		sum     = r.acc + flvds_pkg::SHIFT_STEP;
		if (r.period != '0)
		begin
			if (sum >= modulus)
			begin
				n.acc   = sum - modulus;
				n.shift = 1'b1;
				if (r.slot == flvds_pkg::LAST_SLOT)
					n.slot = '0;
				else
					n.slot = r.slot + 3'h1;
				n.load = (r.slot == flvds_pkg::LAST_SLOT);
			end
			else
			begin
				n.acc = sum;
			end
		end

		//////////////////////////////////////////////////////////////////////////
		// Pair power: needed lanes by mode, then selections, override and enable.
		for (int i = 0; i < flvds_pkg::LANES - 1; i++)
		begin
			need[flvds_pkg::LANE_A0+i] = 1'b1;
			need[flvds_pkg::LANE_B0+i] = CFG_DUAL_CHANNEL;
		end
		need[flvds_pkg::LANE_A3]   = CFG_COLOR_8BIT;
		need[flvds_pkg::LANE_B3]   = CFG_COLOR_8BIT & CFG_DUAL_CHANNEL;
		need[flvds_pkg::LANE_CLKA] = 1'b1;
		need[flvds_pkg::LANE_CLKB] = CFG_DUAL_CHANNEL;
		if (!r.port_en)
			n.pwr = '0;
		else if (SEQ_OVERRIDE_EN && SEQ_IN_PROGRESS)
			n.pwr = {flvds_pkg::NUM_PAIRS{SEQ_DRIVERS_ON}};
		else
			n.pwr = need & ~PAIR_PD_SEL;

		//////////////////////////////////////////////////////////////////////////
		// Words for the next load; a powered-down pair sends zeros.
		for (int i = 0; i < flvds_pkg::LANES; i++)
		begin
			words[flvds_pkg::LANE_A0+i] = r.pwr[flvds_pkg::LANE_A0+i] ? r.ready_a[i] : '0;
			words[flvds_pkg::LANE_B0+i] = r.pwr[flvds_pkg::LANE_B0+i] ? r.ready_b[i] : '0;
		end
		words[flvds_pkg::LANE_CLKA] = r.pwr[flvds_pkg::LANE_CLKA] ? flvds_pkg::CLK_PATTERN : '0;
		words[flvds_pkg::LANE_CLKB] = r.pwr[flvds_pkg::LANE_CLKB] ? flvds_pkg::CLK_PATTERN : '0;
	end

	// Mode writes never reset the shift engine, so timing bits keep flowing.
	always_ff @(posedge CLOCK)
	begin
		if (SYS_RST)
			r <= flvds_pkg::TOP_RESET;
		else
			r <= n;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs

	assign ser.load  = r.load;
	assign ser.shift = r.shift;
	assign ser.words = words;

	assign LVDS_SERIAL          = ser.bits;
	assign PAIR_POWER_ON        = r.pwr;
	assign TMG_VALUE            = r.tmg;
	assign TMG_LOCKED           = r.lock;
	assign ACTIVE_SRC_SIZE      = r.src_size;
	assign HIGH_RESOLUTION_MODE = ~r.legacy;
	assign TMG_PARITY_ERR       = r.tmg_err;
	assign LINK_RATE_OK         = r.rate_ok;

endmodule // flvds_tx

// File: design/flvds_pkg.sv
// Shared constants, types and helpers of the flat panel differential transmitter.
package flvds_pkg;

	// System clock and the permitted link (dot clock) range, in kHz.
	localparam int CLK_KHZ      = 100000;
	localparam int LINK_MIN_KHZ = 25000;
	localparam int LINK_MAX_KHZ = 112000;

	// Dot period limits in system clock cycles; the shortest never below one cycle.
	localparam int                PERIOD_W       = 8;
	localparam logic [PERIOD_W-1:0] PERIOD_MAX_CYC = PERIOD_W'(CLK_KHZ / LINK_MIN_KHZ);
	localparam logic [PERIOD_W-1:0] PERIOD_MIN_CYC =
		PERIOD_W'((CLK_KHZ / LINK_MAX_KHZ) < 1 ? 1 : (CLK_KHZ / LINK_MAX_KHZ));

	// Serial slot layout.
	localparam int         WORD_W      = 7;
	localparam logic [2:0] LAST_SLOT   = 3'h6;
	localparam logic [9:0] SHIFT_STEP  = 10'h007;
	localparam logic [6:0] CLK_PATTERN = 7'h63;

	// Pair numbering on the serial outputs.
	localparam int NUM_PAIRS = 10;
	localparam int LANES     = 4;
	localparam int LANE_A0   = 0;
	localparam int LANE_A3   = 3;
	localparam int LANE_CLKA = 4;
	localparam int LANE_B0   = 5;
	localparam int LANE_B3   = 8;
	localparam int LANE_CLKB = 9;

	// Panel timing word fields.
	localparam int TMG_HACT_LSB   = 0;
	localparam int TMG_HSYNC_LSB  = 12;
	localparam int TMG_HBLANK_LSB = 22;

	// Pixel word: red, green, blue from the top.
	localparam int PIX_W   = 24;
	localparam int RED_LSB = 16;
	localparam int GRN_LSB = 8;
	localparam int BLU_LSB = 0;

	typedef logic [LANES-1:0][WORD_W-1:0] flvds_chan_t;

	typedef enum logic [0:0] {PAIR_A, PAIR_B} flvds_pair_t;

	typedef struct packed {
		logic                  port_en;
		logic                  lock;
		logic [31:0]           tmg;
		logic [23:0]           src_size;
		logic                  legacy;
		logic                  dot_lvl;
		logic [PIX_W+2:0]      pix_prev;
		logic [PERIOD_W-1:0]   per_cnt;
		logic [PERIOD_W-1:0]   period;
		logic [9:0]            acc;
		logic [2:0]            slot;
		flvds_pair_t           pair;
		logic                  de_prev;
		flvds_chan_t           hold;
		flvds_chan_t           ready_a;
		flvds_chan_t           ready_b;
		logic [NUM_PAIRS-1:0]  pwr;
		logic                  rate_ok;
		logic                  tmg_err;
		logic                  shift;
		logic                  load;
	} flvds_top_t;

	typedef struct packed {
		logic [NUM_PAIRS-1:0][WORD_W-1:0] sh;
		logic [NUM_PAIRS-1:0]             bits;
	} flvds_shf_t;

	localparam flvds_top_t TOP_RESET      = '0;
	localparam flvds_shf_t SHF_RESET      = '0;
	localparam logic [31:0] TMG_RESET      = 32'h0000_0000;
	localparam logic [23:0] SRC_SIZE_RESET = 24'h00_0000;

	// Packs one pixel into four seven-slot words; slot 0 is bit 6.
	function automatic flvds_chan_t flvds_pack(input logic [PIX_W-1:0] pix,
		input logic hs, input logic vs, input logic de, input logic deep);
		logic [5:0] r6;
		logic [5:0] g6;
		logic [5:0] b6;
		flvds_chan_t w;
		r6 = pix[RED_LSB+2 +: 6];
		g6 = pix[GRN_LSB+2 +: 6];
		b6 = pix[BLU_LSB+2 +: 6];
		w[0] = {g6[0], r6};
		w[1] = {b6[1:0], g6[5:1]};
		w[2] = {de, vs, hs, b6[5:2]};
		w[3] = deep ? {1'b0, pix[BLU_LSB +: 2], pix[GRN_LSB +: 2], pix[RED_LSB +: 2]} : 7'h00;
		return w;
	endfunction

endpackage

// File: design/flvds_ser_if.sv
// Parallel-to-serial hand-off between the transmitter core and its shifter.
`timescale 1ns/1ns
interface flvds_ser_if;
	logic                                                  load;
	logic                                                  shift;
	logic [flvds_pkg::NUM_PAIRS-1:0][flvds_pkg::WORD_W-1:0] words;
	logic [flvds_pkg::NUM_PAIRS-1:0]                       bits;

	modport core (output load, output shift, output words, input bits);
	modport shifter (input load, input shift, input words, output bits);
endinterface

// File: design/flvds_sync3.sv
// Three-stage synchroniser for inputs from outside the system clock domain.
`timescale 1ns/1ns
module flvds_sync3
#(
	parameter int W = 1
)
(
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst,
	// Asynchronous input
	input  wire logic [W-1:0] din,
	// Second and third stages
	output wire logic [W-1:0] stage2,
	output wire logic [W-1:0] stage3
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
	} flvds_sync_t;

	flvds_sync_t r;
	flvds_sync_t n;

	always_comb
	begin
		n.s1 = din;
		n.s2 = r.s1;
		n.s3 = r.s2;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			r <= '0;
		else
			r <= n;
	end

	assign stage2 = r.s2;
	assign stage3 = r.s3;

endmodule // flvds_sync3

// File: design/flvds_shifter.sv
// Seven-slot parallel-to-serial shifter for all ten differential pairs.
`timescale 1ns/1ns
module flvds_shifter
(
	// Clock and reset
	input wire logic     clk,
	input wire logic     rst,
	// Words in, serial bits out
	flvds_ser_if.shifter ser
);

	flvds_pkg::flvds_shf_t r;
	flvds_pkg::flvds_shf_t n;

	// A load is also the shift of slot 0, so the word's first bit leaves at once.
	always_comb
	begin
		n = r;
		if (ser.shift)
		begin
			for (int i = 0; i < flvds_pkg::NUM_PAIRS; i++)
			begin
				if (ser.load)
				begin
					n.bits[i] = ser.words[i][flvds_pkg::WORD_W-1];
					n.sh[i]   = {ser.words[i][flvds_pkg::WORD_W-2:0], 1'b0};
				end
				else
				begin
					n.bits[i] = r.sh[i][flvds_pkg::WORD_W-1];
					n.sh[i]   = {r.sh[i][flvds_pkg::WORD_W-2:0], 1'b0};
				end
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			r <= flvds_pkg::SHF_RESET;
		else
			r <= n;
	end

	assign ser.bits = r.bits;

endmodule // flvds_shifter

// File: tb/flvds_rx_model.sv
// Panel receiver model that counts clock pair periods and watches pair activity.
`timescale 1ns/1ns
module flvds_rx_model
(
	// Clock and control
	input  wire logic        clk,
	input  wire logic        clear,
	// Serial pairs
	input  wire logic [9:0]  serial,
	// Observations
	output logic      [15:0] falls_a,
	output logic      [15:0] falls_b,
	output logic      [9:0]  moved
);
	logic [9:0] last;

	// The pattern 1100011 has one falling edge, so each fall marks one word.
	always_ff @(posedge clk)
	begin
		last <= serial;
		if (clear)
		begin
			falls_a <= '0;
			falls_b <= '0;
			moved   <= '0;
		end
		else
		begin
			falls_a <= falls_a + 16'(last[4] & ~serial[4]);
			falls_b <= falls_b + 16'(last[9] & ~serial[9]);
			moved   <= moved | (last ^ serial);
		end
	end
endmodule // flvds_rx_model

// File: tb/flvds_tx_props.sv
// Concurrent checks on the ports of the flat panel transmitter.
`timescale 1ns/1ns
module flvds_tx_props
(
	// Clock and reset
	input wire logic        CLOCK,
	input wire logic        SYS_RST,
	// Configuration and control
	input wire logic        PORT_ENABLE,
	input wire logic        CFG_DUAL_CHANNEL,
	input wire logic        CFG_COLOR_8BIT,
	input wire logic [9:0]  PAIR_PD_SEL,
	input wire logic        SEQ_OVERRIDE_EN,
	input wire logic        SEQ_IN_PROGRESS,
	input wire logic        SEQ_DRIVERS_ON,
	input wire logic        TMG_WR,
	input wire logic [31:0] TMG_WR_DATA,
	input wire logic        TMG_LOCK_SET,
	input wire logic        TMG_LOCK_CLR,
	input wire logic        SRC_SIZE_WR,
	input wire logic [23:0] SRC_SIZE_DATA,
	input wire logic        LEGACY_GFX_EN,
	// Outputs watched
	input wire logic [9:0]  LVDS_SERIAL,
	input wire logic [9:0]  PAIR_POWER_ON,
	input wire logic [31:0] TMG_VALUE,
	input wire logic        TMG_LOCKED,
	input wire logic [23:0] ACTIVE_SRC_SIZE,
	input wire logic        HIGH_RESOLUTION_MODE,
	input wire logic        TMG_PARITY_ERR
);
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (SYS_RST);

	logic ovr;
	assign ovr = SEQ_OVERRIDE_EN && SEQ_IN_PROGRESS;

	// Pairs that the channel mode and colour depth put in use.
	function automatic logic [9:0] lane_need(input logic dual, input logic deep);
		return {dual, deep & dual, {3{dual}}, 1'b1, deep, 3'b111};
	endfunction

	a_port_off_dark: assert property (!PORT_ENABLE [*2] |=> PAIR_POWER_ON == 10'h000)
		else $error("pairs powered while port disabled");
	a_pair_select_power: assert property ((PORT_ENABLE && !ovr && $stable(PAIR_PD_SEL)
		&& $stable(CFG_DUAL_CHANNEL) && $stable(CFG_COLOR_8BIT)) [*3]
		|=> PAIR_POWER_ON == (lane_need($past(CFG_DUAL_CHANNEL), $past(CFG_COLOR_8BIT))
		& ~$past(PAIR_PD_SEL)))
		else $error("pair power differs from its selection");
	a_sequencer_override: assert property ((PORT_ENABLE && ovr && $stable(SEQ_DRIVERS_ON)) [*3]
		|=> PAIR_POWER_ON == {10{$past(SEQ_DRIVERS_ON)}})
		else $error("sequencer override not applied");
	a_timing_write: assert property (TMG_WR && !TMG_LOCKED |=> TMG_VALUE == $past(TMG_WR_DATA))
		else $error("timing write not taken");
	a_locked_hold: assert property (TMG_LOCKED |=> $stable(TMG_VALUE))
		else $error("locked timing changed");
	a_lock_set_clr: assert property ((TMG_LOCK_SET |=> TMG_LOCKED) and
		(TMG_LOCK_CLR && !TMG_LOCK_SET |=> !TMG_LOCKED))
		else $error("lock state wrong");
	a_src_size_take: assert property (SRC_SIZE_WR |=> ACTIVE_SRC_SIZE == $past(SRC_SIZE_DATA))
		else $error("source size not taken");
	a_mode_follows: assert property (1'b1 |=> HIGH_RESOLUTION_MODE == !$past(LEGACY_GFX_EN))
		else $error("resolution mode does not follow legacy enable");
	a_even_timing: assert property (($stable(CFG_DUAL_CHANNEL) && $stable(TMG_VALUE)) [*2]
		|-> TMG_PARITY_ERR == (CFG_DUAL_CHANNEL && (TMG_VALUE[0] || TMG_VALUE[12] || TMG_VALUE[22])))
		else $error("odd timing flag wrong");
	a_clock_keeps: assert property ($fell(LVDS_SERIAL[4]) && PAIR_POWER_ON[4]
		|-> ##[2:40] ($fell(LVDS_SERIAL[4]) || !PAIR_POWER_ON[4]))
		else $error("clock pair stalled");

	c_lock: cover property (TMG_LOCKED && TMG_WR);
	c_override: cover property (PORT_ENABLE && ovr);
	c_dual_clock: cover property (CFG_DUAL_CHANNEL && $fell(LVDS_SERIAL[9]));
endmodule // flvds_tx_props

bind flvds_tx flvds_tx_props i_props (.CLOCK, .SYS_RST, .PORT_ENABLE, .CFG_DUAL_CHANNEL,
	.CFG_COLOR_8BIT,
	.PAIR_PD_SEL, .SEQ_OVERRIDE_EN, .SEQ_IN_PROGRESS, .SEQ_DRIVERS_ON, .TMG_WR, .TMG_WR_DATA,
	.TMG_LOCK_SET, .TMG_LOCK_CLR, .SRC_SIZE_WR, .SRC_SIZE_DATA, .LEGACY_GFX_EN, .LVDS_SERIAL,
	.PAIR_POWER_ON, .TMG_VALUE, .TMG_LOCKED, .ACTIVE_SRC_SIZE, .HIGH_RESOLUTION_MODE,
	.TMG_PARITY_ERR);

// File: tb/testbench.sv
// Self-checking bench for the flat panel transmitter.
`timescale 1ns/1ns
module testbench;
	logic        CLOCK, SYS_RST, DOT_CLK, PIX_HSYNC, PIX_VSYNC, PIX_DISPLAY_ACTIVE_FLAG;
	logic [23:0] PIX_DATA, SRC_SIZE_DATA, ACTIVE_SRC_SIZE;
	logic        PORT_ENABLE, CFG_DUAL_CHANNEL, CFG_COLOR_8BIT, SEQ_OVERRIDE_EN;
	logic        SEQ_IN_PROGRESS, SEQ_DRIVERS_ON, TMG_WR, TMG_LOCK_SET, TMG_LOCK_CLR;
	logic        SRC_SIZE_WR, LEGACY_GFX_EN, TMG_LOCKED, HIGH_RESOLUTION_MODE;
	logic        TMG_PARITY_ERR, LINK_RATE_OK, rx_clear;
	logic [9:0]  PAIR_PD_SEL, LVDS_SERIAL, PAIR_POWER_ON, moved;
	logic [31:0] TMG_WR_DATA, TMG_VALUE;
	logic [15:0] falls_a, falls_b;
	logic [1:0]  pix_mode;
	logic [13:0] r;
	int          mismatches, checks_done;

	flvds_tx i_dut (.*);
	flvds_rx_model i_rx (.clk(CLOCK), .clear(rx_clear), .serial(LVDS_SERIAL), .falls_a,
		.falls_b, .moved);

	initial
	begin
		CLOCK = 0;
		forever #5 CLOCK = ~CLOCK;
	end
	// Odd offset keeps the dot clock out of phase with the system clock.
	initial
	begin
		DOT_CLK = 0;
		#3;
		forever #40 DOT_CLK = ~DOT_CLK;
	end
	// Mode 0 sends zeros, mode 1 all ones, otherwise random pixels.
	always @(posedge DOT_CLK)
	begin
		PIX_DATA <= pix_mode == 2'h0 ? 24'h000000 : pix_mode == 2'h1 ? 24'hFFFFFF : $urandom;
		{PIX_HSYNC, PIX_VSYNC, PIX_DISPLAY_ACTIVE_FLAG} <=
			pix_mode[1] ? 3'($urandom) : {3{pix_mode[0]}};
	end

	task automatic cyc(input int n);
		repeat (n) @(negedge CLOCK);
	endtask
	task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			mismatches++;
			$display("unexpected at %0t: got %h, wanted %h", $time, got, exp);
		end
	endtask
	task automatic check_range(input logic [15:0] got, input int lo, input int hi);
		checks_done++;
		if (got < lo || got > hi || $isunknown(got))
		begin
			mismatches++;
			$display("unexpected at %0t: count %0d outside %0d..%0d", $time, got, lo, hi);
		end
	endtask
	task automatic tmg(input logic [31:0] d);
		TMG_WR_DATA = d;
		TMG_WR = 1;
		cyc(1);
		TMG_WR = 0;
		cyc(1);
	endtask
	task automatic settle();
		cyc(60);
		rx_clear = 1;
		cyc(1);
		rx_clear = 0;
		cyc(40);
	endtask
	function automatic logic [9:0] exp_power();
		if (!PORT_ENABLE)
			return 10'h000;
		if (SEQ_OVERRIDE_EN && SEQ_IN_PROGRESS)
			return {10{SEQ_DRIVERS_ON}};
		return {CFG_DUAL_CHANNEL, CFG_COLOR_8BIT & CFG_DUAL_CHANNEL, {3{CFG_DUAL_CHANNEL}},
			1'b1, CFG_COLOR_8BIT, 3'b111} & ~PAIR_PD_SEL;
	endfunction
	task automatic print_verdict();
		$display("checks %0d, mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	initial
	begin
		#100000;
		mismatches++;
		print_verdict();
	end

	initial
	begin
		{PORT_ENABLE, CFG_DUAL_CHANNEL, CFG_COLOR_8BIT, SEQ_OVERRIDE_EN, SEQ_IN_PROGRESS} = '0;
		{SEQ_DRIVERS_ON, TMG_WR, TMG_LOCK_SET, TMG_LOCK_CLR, SRC_SIZE_WR, LEGACY_GFX_EN} = '0;
		{PAIR_PD_SEL, TMG_WR_DATA, SRC_SIZE_DATA, pix_mode, rx_clear} = '0;
		SYS_RST = 1;
		void'($urandom(41));
		cyc(16);
		SYS_RST = 0;
		cyc(1);
		check_word(PAIR_POWER_ON, 0);
		check_word(HIGH_RESOLUTION_MODE, 1);
		tmg(32'h0080_2400);
		check_word(TMG_VALUE, 32'h0080_2400);
		TMG_LOCK_SET = 1;
		cyc(1);
		TMG_LOCK_SET = 0;
		tmg(32'h1111_1111);
		check_word(TMG_VALUE, 32'h0080_2400);
		SRC_SIZE_DATA = 24'h3FF2FF;
		SRC_SIZE_WR = 1;
		cyc(1);
		SRC_SIZE_WR = 0;
		LEGACY_GFX_EN = 1;
		cyc(1);
		check_word(ACTIVE_SRC_SIZE, 24'h3FF2FF);
		check_word(HIGH_RESOLUTION_MODE, 0);
		TMG_LOCK_CLR = 1;
		cyc(1);
		TMG_LOCK_CLR = 0;
		CFG_DUAL_CHANNEL = 1;
		tmg(32'h1111_1111);
		cyc(1);
		check_word(TMG_PARITY_ERR, 1);
		tmg(32'h0080_2400);
		cyc(1);
		check_word(TMG_PARITY_ERR, 0);
		PORT_ENABLE = 1;
		pix_mode = 2;
		for (int d = 0; d < 2; d++)
		begin
			CFG_DUAL_CHANNEL = d[0];
			settle();
			cyc(120);
			LEGACY_GFX_EN = ~LEGACY_GFX_EN;
			cyc(160);
			check_range(falls_a, d ? 19 : 39, d ? 21 : 41);
			check_word(LINK_RATE_OK, 0);
			if (d)
				check_range(falls_b, 19, 21);
		end
		for (int i = 0; i < 8; i++)
		begin
			{CFG_DUAL_CHANNEL, CFG_COLOR_8BIT, pix_mode} = {i[2:1], 1'b0, i[0]};
			settle();
			check_word(moved & 10'h0E7, 0);
			check_word(LVDS_SERIAL & 10'h0E7, {3'h0, {3{i[2] & i[0]}}, 2'h0, {3{i[0]}}});
			check_word(moved[3], i[1] & i[0]);
		end
		for (int i = 0; i < 44; i++)
		begin
			r = i == 0 ? 14'h0000 : i == 1 ? 14'h3FFF : i == 2 ? 14'h1FFF : i == 3 ? 14'h3BFF : $urandom;
			{SEQ_DRIVERS_ON, SEQ_IN_PROGRESS, SEQ_OVERRIDE_EN, PORT_ENABLE, PAIR_PD_SEL} = r;
			{CFG_DUAL_CHANNEL, CFG_COLOR_8BIT} = i < 4 ? 2'h3 : 2'($urandom);
			cyc(3);
			check_word(PAIR_POWER_ON, exp_power());
		end
		{SEQ_OVERRIDE_EN, PORT_ENABLE, PAIR_PD_SEL} = {2'b01, 10'h010};
		settle();
		check_word({moved[4], LVDS_SERIAL[4]}, 0);
		PORT_ENABLE = 0;
		settle();
		check_word(moved, 0);
		SYS_RST = 1;
		PORT_ENABLE = 1;
		cyc(3);
		SYS_RST = 0;
		cyc(1);
		check_word({TMG_LOCKED, PAIR_POWER_ON}, 0);
		print_verdict();
	end
endmodule // testbench
